// file: rtl/fault_sup_pkg.sv
// Constants and display codes for the fault supervisor
package fault_sup_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets (32-bit Wishbone words)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SETLIM = 8'h04;
    localparam logic [7:0] OFS_SCALE  = 8'h08;
    localparam logic [7:0] OFS_INDRNG = 8'h0c;
    localparam logic [7:0] OFS_ERRMV  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ----------------------------------------------------------------
    // Control register fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_KIND_LSB  = 0;
    localparam int CTRL_UNIT_F    = 2;
    localparam int CTRL_AUX_ERR   = 3;
    localparam int CTRL_CTL_ERR   = 4;
    localparam int CTRL_MV_EN     = 5;
    localparam logic [5:0]  CTRL_RST   = 6'h00;
    localparam logic [31:0] SETLIM_RST = 32'h0190_0000;
    localparam logic [31:0] SCALE_RST  = 32'h0064_0000;
    localparam logic [31:0] INDRNG_RST = 32'h0190_0000;
    localparam logic [15:0] ERRMV_RST  = 16'h0000;

    // Input kinds
    localparam logic [1:0] KIND_RTD = 2'h0;
    localparam logic [1:0] KIND_TC  = 2'h1;
    localparam logic [1:0] KIND_DED = 2'h2;
    localparam logic [1:0] KIND_ANA = 2'h3;

    // ----------------------------------------------------------------
    // Limits, in display units without decimal point
    // ----------------------------------------------------------------
    localparam logic signed [17:0] MARGIN_C   = 18'sd20;
    localparam logic signed [17:0] MARGIN_F   = 18'sd40;
    localparam logic signed [17:0] ANA_DIV    = 18'sd20;   // span / 20 = 5 percent
    localparam logic signed [17:0] DISP_MIN   = -18'sd1999;
    localparam logic signed [17:0] DISP_MAX   = 18'sd9999;
    localparam logic [11:0]        OVERCUR_DA = 12'd550;   // 55.0 A in 0.1 A steps
    localparam logic signed [17:0] AMB_MIN_C  = -18'sd30;
    localparam logic signed [17:0] AMB_MAX_C  = 18'sd75;
    localparam logic signed [17:0] AMB_MIN_F  = 18'sd10;
    localparam logic signed [17:0] AMB_MAX_F  = 18'sd171;

    // Monitor selections from the display driver
    localparam logic [1:0] MON_NONE = 2'h0;
    localparam logic [1:0] MON_HEAT = 2'h1;
    localparam logic [1:0] MON_LEAK = 2'h2;
    localparam logic [1:0] MON_AMB  = 2'h3;

    // Codes sent to the display driver
    typedef enum logic [3:0] {
        DISP_NUMERIC  = 4'h0,
        DISP_IN_ERR   = 4'h1,
        DISP_UNDER    = 4'h2,
        DISP_OVER     = 4'h3,
        DISP_CONV     = 4'h4,
        DISP_MEM      = 4'h5,
        DISP_OVERCUR  = 4'h6,
        DISP_DASHES   = 4'h7
    } disp_code_e;

endpackage

// file: rtl/range_check.sv
// Signed window comparator
`timescale 1ns/1ps
module range_check
    import fault_sup_pkg::*;
#(
    parameter int W = 18
) (
    // Value and window
    input  wire logic signed [W-1:0] value,
    input  wire logic signed [W-1:0] lo,
    input  wire logic signed [W-1:0] hi,
    // Result
    output logic                     below,
    output logic                     above
);

    // ----------------------------------------------------------------
    // Compare
    // ----------------------------------------------------------------
    // Strict compare: the window bounds themselves are still in range
    always_comb begin
        below = value < lo;
        above = value > hi;
    end

endmodule

// file: rtl/controller_fault_supervisor.sv
// Fault supervisor: input, converter, memory, current and ambient faults
// How it works
// RL1 - Temperature inputs: error beyond limits plus margin
// RL2 - Analog inputs: error outside -5 to 105 percent
// RL3 - Dedicated sensor: range equals indication range
// RL4 - RTD open line counts as disconnection
// RL5 - Input error forces all alarms on
// RL6 - Input error drives transfer to full scale
// RL7 - Error-assigned control or aux output turns on
// RL8 - Input error: heat/cool off or configured value
// RL9 - Input error code shown at PV position
// RL10 - Indications go to display one or two
// RL11 - Under/over pattern when control range wider
// RL12 - Display overflow is no fault
// RL13 - Converter fault: code shown, outputs off
// RL14 - Memory fault: code shown, outputs off
// RL15 - Above 55.0 A shows overcurrent, control continues
// RL16 - Overcurrent shown only on current monitors
// RL17 - Heater alarms flash matching monitor on display one
// RL18 - Celsius ambient outside -30..75 shows dashes
// RL19 - Fahrenheit ambient outside 10..171 shows dashes
// RL20 - Ambient out of range leaves control alone
// RL21 - Converter and memory faults latch until reset
`timescale 1ns/1ps
module controller_fault_supervisor
    import fault_sup_pkg::*;
#(
    parameter int               N_ALARM = 3,
    parameter logic [15:0]      XFER_FULL = 16'hffff
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Measurement front end
    input  wire logic signed [15:0]   process_value,
    input  wire logic [2:0]           rtd_open_line,
    input  wire logic                 sensor_break,
    input  wire logic                 adc_fail,
    input  wire logic                 mem_fail,
    input  wire logic [11:0]          heater_current,
    input  wire logic signed [9:0]    ambient_temp,
    input  wire logic                 heater_burnout_alarm,
    input  wire logic                 heater_short_alarm,
    // Requests from the control loop
    input  wire logic [7:0]           heat_mv_req,
    input  wire logic [7:0]           cool_mv_req,
    input  wire logic                 aux_req,
    input  wire logic [N_ALARM-1:0]   alarm_req,
    input  wire logic [15:0]          transfer_req,
    // Display driver selection
    input  wire logic [1:0]           monitor_sel,
    input  wire logic                 monitor_on_disp2,
    // Supervised outputs
    output logic [7:0]                heat_mv,
    output logic [7:0]                cool_mv,
    output logic                      aux_out,
    output logic                      err_ctl_out,
    output logic [N_ALARM-1:0]        alarm_out,
    output logic [15:0]               transfer_out,
    // Display codes
    output disp_code_e                disp1_code,
    output disp_code_e                disp2_code,
    output logic                      disp1_flash
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic               ack;
        logic [31:0]        rdata;
        logic [5:0]         ctrl;
        logic [31:0]        setlim;
        logic [31:0]        scale;
        logic [31:0]        indrng;
        logic [15:0]        errmv;
        logic               in_err;
        logic               conv;
        logic               mem;
        logic               under;
        logic               over;
        logic               overcur;
        logic               amb_oor;
        logic [7:0]         heat;
        logic [7:0]         cool;
        logic               aux;
        logic               errctl;
        logic [N_ALARM-1:0] alarm;
        logic [15:0]        xfer;
        disp_code_e         d1;
        disp_code_e         d2;
        logic               flash;
    } state_s;

    state_s st_q;
    state_s st_d;

    // ----------------------------------------------------------------
    // Range windows
    // ----------------------------------------------------------------
    logic signed [17:0] ctl_lo;
    logic signed [17:0] ctl_hi;
    logic signed [17:0] span;
    logic signed [17:0] margin;
    logic signed [17:0] chk_val [3];
    logic signed [17:0] chk_lo  [3];
    logic signed [17:0] chk_hi  [3];
    logic [2:0]         chk_below;
    logic [2:0]         chk_above;
    logic [1:0]         kind;
    logic               unit_f;

    assign kind   = st_q.ctrl[CTRL_KIND_LSB +: 2];
    assign unit_f = st_q.ctrl[CTRL_UNIT_F];
    assign margin = unit_f ? MARGIN_F : MARGIN_C; // RL1
    assign span   = 18'(signed'(st_q.scale[31:16])) - 18'(signed'(st_q.scale[15:0]));

    // Control range per kind; the divide is slow but
    // only moves when software rewrites scaling
    always_comb begin
        case (kind)
            KIND_DED: begin
                ctl_lo = 18'(signed'(st_q.indrng[15:0])); // RL3
                ctl_hi = 18'(signed'(st_q.indrng[31:16])); // RL3
            end
            KIND_ANA: begin
                ctl_lo = 18'(signed'(st_q.scale[15:0])) - span / ANA_DIV; // RL2
                ctl_hi = 18'(signed'(st_q.scale[31:16])) + span / ANA_DIV; // RL2
            end
            default: begin
                ctl_lo = 18'(signed'(st_q.setlim[15:0])) - margin; // RL1
                ctl_hi = 18'(signed'(st_q.setlim[31:16])) + margin; // RL1
            end
        endcase
    end

    // Window 0 control range, 1 display range, 2 ambient range
    always_comb begin
        chk_val[0] = 18'(process_value);
        chk_lo[0]  = ctl_lo;
        chk_hi[0]  = ctl_hi;
        chk_val[1] = 18'(process_value);
        chk_lo[1]  = DISP_MIN;
        chk_hi[1]  = DISP_MAX;
        chk_val[2] = 18'(ambient_temp);
        chk_lo[2]  = unit_f ? AMB_MIN_F : AMB_MIN_C; // RL18 RL19
        chk_hi[2]  = unit_f ? AMB_MAX_F : AMB_MAX_C; // RL18 RL19
    end

    for (genvar i = 0; i < 3; i++) begin : g_win
        range_check #(
            .W     (18)
        ) u_win (
            .value (chk_val[i]),
            .lo    (chk_lo[i]),
            .hi    (chk_hi[i]),
            .below (chk_below[i]),
            .above (chk_above[i])
        );
    end

    // ----------------------------------------------------------------
    // Register write merge
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic        bus_req;
    logic        wide_rng;
    logic        open_in;
    logic        any_hard;
    logic        cur_mon;
    disp_code_e  mon_code;
    logic [31:0] tmp;

    always_comb begin
        st_d     = st_q;
        tmp      = 32'h0000_0000;
        bus_req  = wb_cyc_i && wb_stb_i && !st_q.ack;

        // Bus: one wait state, ack for a single cycle, unmapped reads zero
        st_d.ack = bus_req;
        if (bus_req) begin
            st_d.rdata = 32'h0000_0000;
            case (wb_adr_i)
                OFS_CTRL:   st_d.rdata = {26'h0, st_q.ctrl};
                OFS_SETLIM: st_d.rdata = st_q.setlim;
                OFS_SCALE:  st_d.rdata = st_q.scale;
                OFS_INDRNG: st_d.rdata = st_q.indrng;
                OFS_ERRMV:  st_d.rdata = {16'h0, st_q.errmv};
                OFS_STATUS: st_d.rdata = {24'h0, |rtd_open_line, st_q.amb_oor,
                                          st_q.overcur, st_q.over, st_q.under,
                                          st_q.mem, st_q.conv, st_q.in_err};
                default:    st_d.rdata = 32'h0000_0000;
            endcase
            if (wb_we_i) begin
                case (wb_adr_i)
                    OFS_CTRL: begin
                        tmp        = merge({26'h0, st_q.ctrl}, wb_dat_i, wb_sel_i);
                        st_d.ctrl  = tmp[5:0];
                    end
                    OFS_SETLIM: st_d.setlim = merge(st_q.setlim, wb_dat_i, wb_sel_i);
                    OFS_SCALE:  st_d.scale  = merge(st_q.scale, wb_dat_i, wb_sel_i);
                    OFS_INDRNG: st_d.indrng = merge(st_q.indrng, wb_dat_i, wb_sel_i);
                    OFS_ERRMV: begin
                        tmp        = merge({16'h0, st_q.errmv}, wb_dat_i, wb_sel_i);
                        st_d.errmv = tmp[15:0];
                    end
                    default: ;
                endcase
            end
        end

        // Fault detection; hard faults only ever set, reset alone clears them
        st_d.conv = st_q.conv || adc_fail; // RL21
        st_d.mem  = st_q.mem || mem_fail; // RL21
        any_hard  = st_d.conv || st_d.mem;
        open_in   = sensor_break || ((kind == KIND_RTD) && (|rtd_open_line)); // RL4
        st_d.in_err  = open_in || chk_below[0] || chk_above[0]; // RL1 RL2 RL3
        wide_rng     = (ctl_lo < DISP_MIN) || (ctl_hi > DISP_MAX);
        st_d.under   = !st_d.in_err && wide_rng && chk_below[1]; // RL11 RL12
        st_d.over    = !st_d.in_err && wide_rng && chk_above[1]; // RL11 RL12
        st_d.overcur = heater_current > OVERCUR_DA; // RL15
        st_d.amb_oor = chk_below[2] || chk_above[2]; // RL18 RL19

        // Pass-through unless a fault takes over;
        // overflow, overcurrent and ambient have no say
        st_d.heat   = heat_mv_req; // RL15 RL20 RL12
        st_d.cool   = cool_mv_req;
        st_d.aux    = aux_req;
        st_d.errctl = 1'b0;
        st_d.alarm  = alarm_req;
        st_d.xfer   = transfer_req;
        if (any_hard) begin
            st_d.heat  = 8'h00; // RL13 RL14
            st_d.cool  = 8'h00; // RL13 RL14
            st_d.aux   = 1'b0; // RL13 RL14
            st_d.xfer  = 16'h0000; // RL13 RL14
            st_d.alarm = '0;
        end else if (st_d.in_err) begin
            st_d.alarm  = '1; // RL5
            st_d.xfer   = XFER_FULL; // RL6
            st_d.errctl = st_q.ctrl[CTRL_CTL_ERR]; // RL7
            if (st_q.ctrl[CTRL_AUX_ERR]) begin
                st_d.aux = 1'b1; // RL7
            end
            if (st_q.ctrl[CTRL_MV_EN]) begin
                st_d.heat = st_q.errmv[7:0]; // RL8
                st_d.cool = st_q.errmv[15:8]; // RL8
            end else begin
                st_d.heat = 8'h00; // RL8
                st_d.cool = 8'h00; // RL8
            end
        end

        // Monitor indication for whichever display shows the monitor
        cur_mon  = (monitor_sel == MON_HEAT) || (monitor_sel == MON_LEAK);
        mon_code = DISP_NUMERIC;
        if (cur_mon && st_d.overcur) begin
            mon_code = DISP_OVERCUR; // RL16
        end else if ((monitor_sel == MON_AMB) && st_d.amb_oor) begin
            mon_code = DISP_DASHES; // RL18 RL19
        end

        // Display one carries the process value position
        if (st_d.mem) begin
            st_d.d1 = DISP_MEM; // RL14
        end else if (st_d.conv) begin
            st_d.d1 = DISP_CONV; // RL13
        end else if (st_d.in_err) begin
            st_d.d1 = DISP_IN_ERR; // RL9
        end else if (st_d.under) begin
            st_d.d1 = DISP_UNDER; // RL11
        end else if (st_d.over) begin
            st_d.d1 = DISP_OVER; // RL11
        end else if (!monitor_on_disp2 && (monitor_sel != MON_NONE)) begin
            st_d.d1 = mon_code; // RL10
        end else begin
            st_d.d1 = DISP_NUMERIC;
        end
        st_d.d2 = (monitor_on_disp2 && (monitor_sel != MON_NONE)) ? mon_code
                                                                   : DISP_NUMERIC; // RL10
        st_d.flash = (heater_burnout_alarm && (monitor_sel == MON_HEAT)) ||
                     (heater_short_alarm && (monitor_sel == MON_LEAK)); // RL17
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q        <= '0;
            st_q.ctrl   <= CTRL_RST;
            st_q.setlim <= SETLIM_RST;
            st_q.scale  <= SCALE_RST;
            st_q.indrng <= INDRNG_RST;
            st_q.errmv  <= ERRMV_RST;
            st_q.d1     <= DISP_NUMERIC;
            st_q.d2     <= DISP_NUMERIC;
        end else begin
            st_q <= st_d;
        end
    end

    // Every output straight from the state register
    assign wb_ack_o     = st_q.ack;
    assign wb_dat_o     = st_q.rdata;
    assign heat_mv      = st_q.heat;
    assign cool_mv      = st_q.cool;
    assign aux_out      = st_q.aux;
    assign err_ctl_out  = st_q.errctl;
    assign alarm_out    = st_q.alarm;
    assign transfer_out = st_q.xfer;
    assign disp1_code   = st_q.d1;
    assign disp2_code   = st_q.d2;
    assign disp1_flash  = st_q.flash;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_conv_latched: assert property (st_q.conv |=> st_q.conv) // RL21
        else $error("converter fault cleared without reset");
    a_mem_latched: assert property (st_q.mem |=> st_q.mem) // RL21
        else $error("memory fault cleared without reset");
    a_hard_off: assert property ((st_q.conv || st_q.mem) |->
                                 (heat_mv == 8'h00 && cool_mv == 8'h00 &&
                                  !aux_out && transfer_out == 16'h0000)) // RL13
        else $error("outputs not off under hard fault");
    a_mem_code: assert property ($rose(st_q.mem) |-> disp1_code == DISP_MEM) // RL14
        else $error("memory code not shown");
    a_err_alarms: assert property ((st_q.in_err && !st_q.conv && !st_q.mem) |->
                                   (alarm_out == '1 && transfer_out == XFER_FULL)) // RL5
        else $error("alarms or transfer not forced on input error");
    a_err_code: assert property ((st_q.in_err && !st_q.conv && !st_q.mem) |->
                                 disp1_code == DISP_IN_ERR) // RL9
        else $error("input error code missing");
    a_rtd_open: assert property ((kind == KIND_RTD && |rtd_open_line && !st_q.ack)
                                 |=> st_q.in_err) // RL4
        else $error("open line not flagged");
    a_overcur: assert property ((heater_current > OVERCUR_DA &&
                                 monitor_sel == MON_HEAT && monitor_on_disp2)
                                |=> disp2_code == DISP_OVERCUR) // RL16
        else $error("overcurrent not shown on monitor");
    a_ctl_continue: assert property ((!st_d.conv && !st_d.mem && !st_d.in_err)
                                     |=> heat_mv == $past(heat_mv_req)) // RL20
        else $error("control disturbed without fault");
    a_flash: assert property ((heater_burnout_alarm && monitor_sel == MON_HEAT)
                              |=> disp1_flash) // RL17
        else $error("heater burnout flash missing");
    a_bus_ack: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

    c_input_err: cover property ($rose(st_q.in_err));
    c_conv_fault: cover property ($rose(st_q.conv));
    c_underrange: cover property (disp1_code == DISP_UNDER);
    c_ambient: cover property (disp2_code == DISP_DASHES);

endmodule

// file: verif/front_end_model.sv
// Front-end model driving measurements
`timescale 1ns/1ps
module front_end_model (
    // Clock
    input  wire logic          ref_clk,
    // Measurements
    output logic signed [15:0] process_value,
    output logic [2:0]         rtd_open_line,
    output logic               sensor_break,
    output logic               adc_fail,
    output logic               mem_fail,
    output logic [11:0]        heater_current,
    output logic signed [9:0]  ambient_temp,
    output logic               heater_burnout_alarm,
    output logic               heater_short_alarm
);
    // Idle, fault-free start
    initial begin
        {process_value, rtd_open_line, sensor_break, adc_fail, mem_fail} = '0;
        {heater_current, ambient_temp, heater_burnout_alarm, heater_short_alarm} = '0;
    end

    // New result just after an edge
    task automatic present(input int pv, input int op, input int brk, input int af,
                           input int mf, input int cur, input int amb, input int hb,
                           input int hs);
        @(posedge ref_clk);
        {process_value, rtd_open_line, sensor_break, adc_fail} <= {16'(pv), 3'(op), 1'(brk), 1'(af)};
        {mem_fail, heater_current, ambient_temp} <= {1'(mf), 12'(cur), 10'(amb)};
        {heater_burnout_alarm, heater_short_alarm} <= {1'(hb), 1'(hs)};
    endtask
endmodule

// file: verif/controller_fault_supervisor_tb.sv
// Bench for the fault supervisor
`timescale 1ns/1ps
module controller_fault_supervisor_tb;
    import fault_sup_pkg::*;
    logic               ref_clk;
    logic               reset_n = 1'b0;
    logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]         wb_adr_i = 8'h00;
    logic [3:0]         wb_sel_i = 4'hf;
    logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, rd;
    logic signed [15:0] process_value;
    logic [2:0]         rtd_open_line;
    logic               sensor_break, adc_fail, mem_fail, heater_burnout_alarm;
    logic               heater_short_alarm, aux_out, err_ctl_out, disp1_flash;
    logic [11:0]        heater_current;
    logic signed [9:0]  ambient_temp;
    logic [7:0]         heat_mv_req = 8'h00, cool_mv_req = 8'h00, heat_mv, cool_mv;
    logic               aux_req = 1'b0, monitor_on_disp2 = 1'b0;
    logic [2:0]         alarm_req = 3'h0, alarm_out;
    logic [15:0]        transfer_req = 16'h0, transfer_out;
    logic [1:0]         monitor_sel = 2'h0;
    disp_code_e         disp1_code, disp2_code;
    int                 n_fail, n_checks, cycles, sel_in, on2_in;
    int                 ctrl_m, slo, shi, clo, chi, ilo, ihi, errmv_m, conv_m, mem_m;

    controller_fault_supervisor i_controller_fault_supervisor (.*);
    front_end_model i_front_end_model (.*);

    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Classic cycle; ack seen mid-cycle, released at the edge that samples it
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(negedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        n_fail += (n == 50);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, d);
        wb(a, 1'b0, 32'h0);
        cmp(rd, d);
    endtask

    // Reference model, one cycle after the inputs
    task automatic check_all();
        int lo, hi, m, sp, er, hd, mc, d1, pv, amn, amx;
        @(posedge ref_clk);
        #1;
        pv = process_value;
        m = ctrl_m[2] ? 40 : 20;
        sp = (chi - clo) / 20;
        lo = ctrl_m[1:0] == 2 ? ilo : ctrl_m[1:0] == 3 ? clo - sp : slo - m;
        hi = ctrl_m[1:0] == 2 ? ihi : ctrl_m[1:0] == 3 ? chi + sp : shi + m;
        amn = ctrl_m[2] ? 10 : -30;
        amx = ctrl_m[2] ? 171 : 75;
        er = pv < lo || pv > hi || (rtd_open_line != 0 && ctrl_m[1:0] == 0) || sensor_break;
        hd = conv_m || mem_m;
        mc = (monitor_sel inside {1, 2} && heater_current > 550) ? 6 :
             (monitor_sel == 3 && (ambient_temp < amn || ambient_temp > amx)) ? 7 : 0;
        d1 = mem_m ? 5 : conv_m ? 4 : er ? 1 : (pv < -1999 && lo < -1999) ? 2 :
             (pv > 9999 && hi > 9999) ? 3 : monitor_on_disp2 ? 0 : mc;
        cmp(disp1_code, d1);
        cmp(disp2_code, monitor_on_disp2 ? mc : 0);
        cmp(disp1_flash, (heater_burnout_alarm && monitor_sel == 1) ||
            (heater_short_alarm && monitor_sel == 2));
        cmp(heat_mv, hd ? 0 : er ? (ctrl_m[5] ? errmv_m[7:0] : 0) : heat_mv_req);
        cmp(cool_mv, hd ? 0 : er ? (ctrl_m[5] ? errmv_m[15:8] : 0) : cool_mv_req);
        cmp(alarm_out, hd ? 0 : er ? 7 : alarm_req);
        cmp(transfer_out, hd ? 0 : er ? 32'hffff : transfer_req);
        cmp(aux_out, hd ? 0 : (er && ctrl_m[3]) ? 1 : aux_req);
        cmp(err_ctl_out, !hd && er && ctrl_m[4]);
    endtask

    // Random loop requests prove control passes through
    task automatic run(input int pv, input int op, input int brk, input int af, input int mf,
                       input int cur, input int amb, input int hb, input int hs);
        i_front_end_model.present(pv, op, brk, af, mf, cur, amb, hb, hs);
        {heat_mv_req, cool_mv_req, aux_req, alarm_req} <= 20'($urandom);
        transfer_req <= 16'($urandom);
        monitor_sel <= 2'(sel_in);
        monitor_on_disp2 <= 1'(on2_in);
        check_all();
    endtask

    task automatic nom(input int pv);
        run(pv, 0, 0, 0, 0, 0, 25, 0, 0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int tp[4] = '{0, 2, 3, 1};
        void'($urandom(32'h14045568));
        {shi, chi, ihi} = {32'd400, 32'd100, 32'd400};
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        wb(OFS_SETLIM, 1'b0, 32'h0);
        cmp(rd, SETLIM_RST);
        wb(8'h40, 1'b1, 32'hdead_beef);
        wb(8'h40, 1'b0, 32'h0);
        cmp(rd, 32'h0);
        foreach (tp[i]) begin
            run(420 + tp[i] % 2, tp[i] >> 1, 0, 0, 0, 0, 25, 0, 0);
            run(-20 - tp[i] % 2, 0, tp[i] == 3, 0, 0, 0, 25, 0, 0);
        end
        cfg(OFS_ERRMV, 32'h5a3c);
        errmv_m = 'h5a3c;
        foreach (tp[i]) begin
            ctrl_m = 'h1d | (tp[i] << 4);
            cfg(OFS_CTRL, ctrl_m);
            nom(440 + tp[i] % 2);
            nom(-40 - tp[i] / 2);
        end
        $display("test input limits done");
        ctrl_m = 3;
        cfg(OFS_CTRL, 32'h3);
        cfg(OFS_SCALE, 32'h00c8_ff38);
        {clo, chi} = {-32'sd200, 32'd200};
        foreach (tp[i]) nom(tp[i] < 2 ? 220 + tp[i] : -218 - tp[i]);
        ctrl_m = 2;
        cfg(OFS_CTRL, 32'h2);
        cfg(OFS_INDRNG, 32'h2ee0_f448);
        {ilo, ihi} = {-32'sd3000, 32'd12000};
        foreach (tp[i]) nom(tp[i] < 2 ? 9999 + tp[i] : -1999 - tp[i] * 500);
        nom(12001);
        $display("test range kinds done");
        for (int s = 0; s < 16; s++) begin
            ctrl_m = s[3] ? 4 : 0;
            cfg(OFS_CTRL, ctrl_m);
            {sel_in, on2_in} = {s % 4, (s >> 2) % 2};
            run(100, 0, 0, 0, 0, 551, s[3] ? 172 : 76, 1, 0);
            run(100, 0, 0, 0, 0, 550, s[3] ? 9 : -31, 0, 1);
            run(100, 0, 0, 0, 0, 0, s[3] ? 171 : 75, 0, 0);
        end
        $display("test monitors done");
        conv_m = 1;
        run(100, 0, 0, 1, 0, 0, 25, 0, 0);
        nom(5000);
        mem_m = 1;
        run(100, 0, 0, 0, 1, 0, 25, 0, 0);
        nom(100);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        {conv_m, mem_m, ctrl_m, errmv_m, ilo, clo} = '0;
        {ihi, chi} = {32'd400, 32'd100};
        nom(100);
        $display("test hard faults done");
        end_of_test();
    end
endmodule
